// [mam_pkg.sv]
// constants and types for the multiplexed address mode decoder
package mam_pkg;

	// ----------------------------------------------------------------
	// bus widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 20;
	localparam int PART_W = 10;
	localparam int BANK_W = 4;

	// ----------------------------------------------------------------
	// mode register field positions
	// ----------------------------------------------------------------
	localparam int SEL_HI = 19;
	localparam int SEL_LO = 18;
	localparam int MUX_BIT = 9;
	localparam int DLL_BIT = 8;
	localparam int LAT_HI = 7;
	localparam int LAT_LO = 4;
	localparam int RC_HI = 3;
	localparam int RC_LO = 0;
	localparam int TERM_HI = 4;
	localparam int TERM_LO = 2;
	localparam int TERM_W = 3;

	// ----------------------------------------------------------------
	// register select codes and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] SEL_MR0 = 2'h0;
	localparam logic [1:0] SEL_MR1 = 2'h1;
	localparam logic [1:0] SEL_MR2 = 2'h2;
	localparam logic [ADDR_W-1:0] MR_RESET = 20'h00000;
	localparam logic [2:0] CMD_PINS_IDLE = 3'h7;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic cs_n;
		logic we_n;
		logic ref_n;
	} mam_cmd_type;

	typedef enum {CMD_NOP, CMD_MRS, CMD_AREF, CMD_OTHER} mam_kind_type;

	typedef enum {ST_IDLE, ST_SECOND} mam_state_type;

	typedef struct packed {
		logic multibank;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] row;
	} mam_ref_type;

endpackage

// [mam_sync.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module mam_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_i, // system clock
	input wire logic sys_rst_i, // synchronous reset, high
	input wire logic [W-1:0] d_i, // raw pin levels
	output logic [W-1:0] q_o // synchronised levels
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] q_reg;
	logic [W-1:0] q_next;

	// first stage feeds only the second stage
	always_comb begin
		meta_next = sys_rst_i ? RST_VAL : d_i;
		q_next = sys_rst_i ? RST_VAL : meta_reg;
	end

	// register both stages
	always_ff @(posedge clk_i) begin
		meta_reg <= meta_next;
		q_reg <= q_next;
	end

	assign q_o = q_reg;

endmodule

// [mam_decoder.sv]
// command decoder with mode registers and multiplexed address capture
`timescale 1ns/1ns
// How it works
// RL1: row/column used only for multibank refresh; outside mux mode the row is passed for every refresh
// RL2: bank used only for bank-controlled refresh; outside mux mode the bank is passed for every refresh
// RL3: mode zero write, bit 9 high, enters mux
// RL4: controller may enter mux mode any time
// RL5: controller waits mode write time afterwards
// RL6: controller rewrites mode zero keeping bit 9
// RL7: registers one and two written in two parts
// RL8: controller follows fixed mux power-up order
// RL9: termination settles after mode register two write
// RL10: select bits 00/01/10 pick register, 11 reserved
// RL11: mode zero: select, reserved, mux, DLL, latency, cycle
// RL12: mux parts on two consecutive rising edges
// RL13: reset held low 100ns, termination off
// RL14: 100 NOP clocks before reset release
module mam_decoder (
	input wire logic clk_i, // 10 MHz system clock
	input wire logic sys_rst_i, // synchronous reset, high
	input wire logic rst_n_i, // reset pin, low, asynchronous source
	input wire mam_pkg::mam_cmd_type cmd_i, // command pins
	input wire logic [mam_pkg::ADDR_W-1:0] addr_i, // address pins
	input wire logic [mam_pkg::BANK_W-1:0] bank_i, // bank address pins
	input wire logic multibank_i, // refresh kind: 1 multibank
	output logic mux_mode_o, // multiplexed address mode active
	output logic [mam_pkg::ADDR_W-1:0] mode_reg_zero_o, // first mode register
	output logic [mam_pkg::ADDR_W-1:0] mode_reg_one_o, // second mode register
	output logic [mam_pkg::ADDR_W-1:0] mode_reg_two_o, // third mode register
	output logic dll_enable_o, // DLL enabled
	output logic [3:0] latency_o, // data latency code
	output logic [3:0] row_cycle_field_o, // cycle time code
	output logic ondie_termination_o, // termination enabled
	output logic [mam_pkg::TERM_W-1:0] termination_resistance_o, // termination code
	output logic busy_o, // waiting for second address part
	output logic ref_valid_o, // refresh accepted, one cycle
	output mam_pkg::mam_ref_type ref_o // refresh bank and address
);

	// ----------------------------------------------------------------
	// pin synchronisation
	// ----------------------------------------------------------------
	localparam int SYNC_W = 3 + mam_pkg::ADDR_W + mam_pkg::BANK_W + 2;
	localparam logic [SYNC_W-1:0] SYNC_RST = {mam_pkg::CMD_PINS_IDLE,
		{(SYNC_W - 3){1'b0}}};

	logic [SYNC_W-1:0] sync_q;
	mam_pkg::mam_cmd_type cmd_s;
	logic [mam_pkg::ADDR_W-1:0] addr_s;
	logic [mam_pkg::BANK_W-1:0] bank_s;
	logic multibank_s;
	logic rst_n_s;
	logic rst_all;

	mam_sync #(.W(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.d_i({cmd_i, addr_i, bank_i, multibank_i, rst_n_i}),
		.q_o(sync_q)
	);

	assign {cmd_s, addr_s, bank_s, multibank_s, rst_n_s} = sync_q;
	// reset pin low returns the device to power-up state [RL13]
	assign rst_all = sys_rst_i | ~rst_n_s;

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	function automatic mam_pkg::mam_kind_type decode(input mam_pkg::mam_cmd_type c);
		if (c.cs_n) begin
			return mam_pkg::CMD_NOP;
		end else if (!c.ref_n && !c.we_n) begin
			return mam_pkg::CMD_MRS;
		end else if (!c.ref_n) begin
			return mam_pkg::CMD_AREF;
		end else begin
			return mam_pkg::CMD_OTHER;
		end
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	mam_pkg::mam_state_type state_reg, state_next;
	mam_pkg::mam_kind_type kind_reg, kind_next;
	logic [mam_pkg::PART_W-1:0] first_reg, first_next;
	logic [mam_pkg::BANK_W-1:0] bank_reg, bank_next;
	logic mb_reg, mb_next;
	logic mux_reg, mux_next;
	logic [mam_pkg::ADDR_W-1:0] mr0_reg, mr0_next;
	logic [mam_pkg::ADDR_W-1:0] mr1_reg, mr1_next;
	logic [mam_pkg::ADDR_W-1:0] mr2_reg, mr2_next;
	logic odt_reg, odt_next;
	logic refv_reg, refv_next;
	mam_pkg::mam_ref_type ref_reg, ref_next;

	mam_pkg::mam_kind_type kind_now;
	mam_pkg::mam_kind_type exec_kind;
	logic exec_go;
	logic [mam_pkg::ADDR_W-1:0] exec_addr;
	logic [mam_pkg::BANK_W-1:0] exec_bank;
	logic exec_mb;
	logic [1:0] exec_sel;

	assign kind_now = decode(cmd_s);
	assign exec_sel = exec_addr[mam_pkg::SEL_HI:mam_pkg::SEL_LO];

	// capture parts and pick the command to carry out this cycle
	always_comb begin
		state_next = state_reg;
		kind_next = kind_reg;
		first_next = first_reg;
		bank_next = bank_reg;
		mb_next = mb_reg;
		exec_go = 1'b0;
		exec_kind = kind_now;
		exec_addr = addr_s;
		exec_bank = bank_s;
		exec_mb = multibank_s;
		case (state_reg)
			mam_pkg::ST_IDLE: begin
				if (kind_now != mam_pkg::CMD_NOP && mux_reg) begin
					// first part on this edge, second on the next [RL12]
					state_next = mam_pkg::ST_SECOND;
					kind_next = kind_now;
					first_next = addr_s[mam_pkg::PART_W-1:0];
					bank_next = bank_s;
					mb_next = multibank_s;
				end else begin
					exec_go = (kind_now != mam_pkg::CMD_NOP);
				end
			end
			mam_pkg::ST_SECOND: begin
				// second part fills the upper half [RL12]
				exec_go = 1'b1;
				exec_kind = kind_reg;
				exec_addr = {addr_s[mam_pkg::PART_W-1:0], first_reg};
				exec_bank = bank_reg;
				exec_mb = mb_reg;
				state_next = mam_pkg::ST_IDLE;
			end
			default: begin
				state_next = mam_pkg::ST_IDLE;
			end
		endcase
	end

	// carry out mode writes and refreshes
	always_comb begin
		mux_next = mux_reg;
		mr0_next = mr0_reg;
		mr1_next = mr1_reg;
		mr2_next = mr2_reg;
		odt_next = odt_reg;
		refv_next = 1'b0;
		ref_next = ref_reg;
		if (exec_go && exec_kind == mam_pkg::CMD_MRS) begin
			case (exec_sel) // [RL10]
				mam_pkg::SEL_MR0: begin
					mr0_next = exec_addr; // [RL11]
					mux_next = exec_addr[mam_pkg::MUX_BIT]; // [RL3]
				end
				mam_pkg::SEL_MR1: begin
					mr1_next = exec_addr;
				end
				mam_pkg::SEL_MR2: begin
					mr2_next = exec_addr;
					odt_next = 1'b1; // [RL9]
				end
				default: begin
					// reserved select: write dropped
				end
			endcase
		end
		if (exec_go && exec_kind == mam_pkg::CMD_AREF) begin
			refv_next = 1'b1;
			ref_next.multibank = exec_mb;
			ref_next.bank = exec_bank;
			ref_next.row = exec_addr;
			if (mux_reg) begin
				// unused fields forced to zero so nothing downstream trusts them
				ref_next.bank = exec_mb ? '0 : exec_bank; // [RL2]
				ref_next.row = exec_mb ? exec_addr : '0; // [RL1]
			end
		end
	end

	// register all state; pin reset acts as a full power-up reset
	always_ff @(posedge clk_i) begin
		if (rst_all) begin
			state_reg <= mam_pkg::ST_IDLE;
			kind_reg <= mam_pkg::CMD_NOP;
			first_reg <= '0;
			bank_reg <= '0;
			mb_reg <= 1'b0;
			mux_reg <= 1'b0;
			mr0_reg <= mam_pkg::MR_RESET;
			mr1_reg <= mam_pkg::MR_RESET;
			mr2_reg <= mam_pkg::MR_RESET;
			odt_reg <= 1'b0; // [RL13]
			refv_reg <= 1'b0;
			ref_reg <= '0;
		end else begin
			state_reg <= state_next;
			kind_reg <= kind_next;
			first_reg <= first_next;
			bank_reg <= bank_next;
			mb_reg <= mb_next;
			mux_reg <= mux_next;
			mr0_reg <= mr0_next;
			mr1_reg <= mr1_next;
			mr2_reg <= mr2_next;
			odt_reg <= odt_next;
			refv_reg <= refv_next;
			ref_reg <= ref_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign mux_mode_o = mux_reg;
	assign mode_reg_zero_o = mr0_reg;
	assign mode_reg_one_o = mr1_reg;
	assign mode_reg_two_o = mr2_reg;
	// field split of the first mode register [RL11]
	assign dll_enable_o = ~mr0_reg[mam_pkg::DLL_BIT];
	assign latency_o = mr0_reg[mam_pkg::LAT_HI:mam_pkg::LAT_LO];
	assign row_cycle_field_o = mr0_reg[mam_pkg::RC_HI:mam_pkg::RC_LO];
	// code zero means high impedance [RL9]
	assign ondie_termination_o = odt_reg;
	assign termination_resistance_o = odt_reg ?
		mr1_reg[mam_pkg::TERM_HI:mam_pkg::TERM_LO] : '0;
	assign busy_o = (state_reg == mam_pkg::ST_SECOND);
	assign ref_valid_o = refv_reg;
	assign ref_o = ref_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_mux_entry: assert property (@(posedge clk_i) disable iff (rst_all) // [RL3]
		(exec_go && exec_kind == mam_pkg::CMD_MRS && exec_sel == mam_pkg::SEL_MR0
		&& exec_addr[mam_pkg::MUX_BIT]) |=> mux_mode_o)
		else $error("mux mode not entered after mode zero write");

	chk_sel_decode: assert property (@(posedge clk_i) disable iff (rst_all) // [RL10]
		$changed(mode_reg_one_o) |-> $past(exec_go && exec_kind == mam_pkg::CMD_MRS
		&& exec_sel == mam_pkg::SEL_MR1))
		else $error("mode register one changed without its select");

	chk_mr0_fields: assert property (@(posedge clk_i) disable iff (rst_all) // [RL11]
		(exec_go && exec_kind == mam_pkg::CMD_MRS && exec_sel == mam_pkg::SEL_MR0)
		|=> (dll_enable_o == !$past(exec_addr[mam_pkg::DLL_BIT]))
		&& (latency_o == $past(exec_addr[mam_pkg::LAT_HI:mam_pkg::LAT_LO])))
		else $error("mode zero fields wrong");

	chk_row_ignored: assert property (@(posedge clk_i) disable iff (rst_all) // [RL1]
		(ref_valid_o && $past(mux_mode_o) && !ref_o.multibank) |-> ref_o.row == '0)
		else $error("row address passed for bank refresh");

	chk_bank_ignored: assert property (@(posedge clk_i) disable iff (rst_all) // [RL2]
		(ref_valid_o && $past(mux_mode_o) && ref_o.multibank) |-> ref_o.bank == '0)
		else $error("bank passed for multibank refresh");

	chk_odt_after_mr2: assert property (@(posedge clk_i) disable iff (rst_all) // [RL9]
		$rose(ondie_termination_o) |-> $past(exec_go && exec_kind == mam_pkg::CMD_MRS
		&& exec_sel == mam_pkg::SEL_MR2))
		else $error("termination enabled without mode register two write");

	chk_two_parts: assert property (@(posedge clk_i) disable iff (rst_all) // [RL12]
		(!busy_o && mux_mode_o && kind_now != mam_pkg::CMD_NOP)
		|=> busy_o ##1 !busy_o)
		else $error("mux command not taken over two edges");

endmodule

// [mam_ctrl_model.sv]
// controller model that drives the command, address and reset pins
`timescale 1ns/1ns
module mam_ctrl_model #(
	parameter int WAIT_CYC = 4 // mode write wait time in cycles
) (
	input wire logic clk_i, // system clock
	output mam_pkg::mam_cmd_type cmd_o, // command pins
	output logic [mam_pkg::ADDR_W-1:0] addr_o, // address pins
	output logic [mam_pkg::BANK_W-1:0] bank_o, // bank pins
	output logic multibank_o, // refresh kind
	output logic rst_n_o // reset pin, low
);
	// ----------------------------------------------------------------
	// pin drivers
	// ----------------------------------------------------------------
	logic mux_reg = 1'b0; // mode the controller believes the device is in
	initial begin
		cmd_o = mam_pkg::CMD_PINS_IDLE;
		addr_o = '0;
		bank_o = '0;
		multibank_o = 1'b0;
		rst_n_o = 1'b1;
	end
	// every change lands a fixed 10 ns after the rising edge
	task automatic step(input logic [2:0] c, input logic [19:0] a, input logic [3:0] b);
		@(posedge clk_i);
		#10;
		cmd_o = c;
		addr_o = a;
		bank_o = b;
	endtask
	// idle pins toggle, so a stale address never looks valid
	task automatic nop(input int n);
		for (int i = 0; i < n; i++) begin
			step(mam_pkg::CMD_PINS_IDLE, ~addr_o, ~bank_o);
		end
	endtask
	// one command; split in two parts while multiplexed
	task automatic issue(input logic mode_reg_write_cmd, input logic [19:0] v, input logic [3:0] b,
		input logic mb);
		logic [2:0] c;
		c = mode_reg_write_cmd ? 3'h0 : 3'h2;
		multibank_o = mb;
		if (mux_reg) begin
			step(c, {10'($urandom), v[9:0]}, b);
			step(mam_pkg::CMD_PINS_IDLE, {10'($urandom), v[19:10]}, ~b);
		end else begin
			step(c, v, b);
		end
		if (mode_reg_write_cmd && v[19:18] == mam_pkg::SEL_MR0) begin
			if (v[9] && !mux_reg) begin
				nop(WAIT_CYC);
			end
			mux_reg = v[9];
		end
	endtask
	// reset pin low for a hundred idle clocks, well over 100 ns
	task automatic pin_reset;
		rst_n_o = 1'b0;
		nop(100);
		rst_n_o = 1'b1;
		mux_reg = 1'b0;
	endtask
endmodule

// [mux_address_mode_init_tb.sv]
// self-checking bench for the multiplexed address mode decoder
`timescale 1ns/1ns
module mux_address_mode_init_tb;
	// ----------------------------------------------------------------
	// wiring and checks
	// ----------------------------------------------------------------
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	mam_pkg::mam_cmd_type cmd;
	mam_pkg::mam_ref_type ref_q;
	logic [19:0] addr, mr0, mr1, mr2, v0, v1, v2, row;
	logic [3:0] bank, lat, rc, b;
	logic [2:0] term;
	logic multibank, rst_n, mux_mode, dll_en, ondie_termination, busy, ref_valid;
	int n_fail = 0;
	int check_count = 0;
	always #50 clk_i = ~clk_i;
	mam_ctrl_model #(.WAIT_CYC(4)) model (.clk_i(clk_i), .cmd_o(cmd), .addr_o(addr),
		.bank_o(bank), .multibank_o(multibank), .rst_n_o(rst_n));
	mam_decoder uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .rst_n_i(rst_n), .cmd_i(cmd),
		.addr_i(addr), .bank_i(bank), .multibank_i(multibank), .mux_mode_o(mux_mode),
		.mode_reg_zero_o(mr0), .mode_reg_one_o(mr1), .mode_reg_two_o(mr2),
		.dll_enable_o(dll_en), .latency_o(lat), .row_cycle_field_o(rc),
		.ondie_termination_o(ondie_termination), .termination_resistance_o(term), .busy_o(busy),
		.ref_valid_o(ref_valid), .ref_o(ref_q));
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	// mode zero word: select 00, reserved zero, mux bit, random low fields
	function automatic logic [19:0] mode_zero(input logic mux);
		return {10'h000, mux, 9'($urandom)};
	endfunction
	function automatic logic [2:0] exp_term(input logic [19:0] m1, input logic on);
		return on ? m1[mam_pkg::TERM_HI:mam_pkg::TERM_LO] : 3'h0;
	endfunction
	// refresh result: both fields pass outside mux mode, unused field zero inside it
	function automatic logic [24:0] exp_ref(input logic mx, input logic mb, input logic [3:0] bk,
		input logic [19:0] rw);
		if (!mx) begin
			return {mb, bk, rw};
		end
		return mb ? {1'b1, 4'h0, rw} : {1'b0, bk, 20'h00000};
	endfunction
	// mode write with random bank pins, which the device must ignore
	task automatic mode_write(input logic [19:0] v);
		model.issue(1'b1, v, 4'($urandom), 1'($urandom));
		model.nop(3);
	endtask
	task automatic check_mode_zero(input logic [19:0] v);
		cmp(mr0, v);
		cmp({mux_mode, dll_en, lat, rc}, {v[9], ~v[8], v[7:0]});
	endtask
	// power-up state: only the dll enable reads high
	task automatic check_reset;
		cmp({mux_mode, dll_en, ondie_termination, term, busy, ref_valid}, 8'h40);
		cmp(mr0 | mr1 | mr2, 20'h00000);
	endtask
	// one refresh; busy only shows while a second address part is due
	task automatic refresh(input logic mb);
		logic mx;
		mx = model.mux_reg;
		b = 4'($urandom);
		row = 20'($urandom);
		model.issue(1'b0, row, b, mb);
		model.nop(2);
		cmp(busy, mx);
		model.nop(1);
		cmp(ref_valid, 1'b1);
		cmp(ref_q, exp_ref(mx, mb, b, row));
		model.nop(1);
		cmp(ref_valid, 1'b0);
	endtask
	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// main sequence: bring-up, writes, refreshes, pin reset
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(46037));
		repeat (5) @(posedge clk_i);
		#10;
		sys_rst_i = 1'b0;
		model.nop(3);
		check_reset();
		for (int r = 0; r < 4; r++) begin
			v0 = mode_zero(1'b1);
			mode_write(v0);
			check_mode_zero(v0);
			v0 = mode_zero(1'b1);
			mode_write(v0);
			check_mode_zero(v0);
			v1 = {mam_pkg::SEL_MR1, 18'($urandom)};
			mode_write(v1);
			cmp({ondie_termination, mr1[17:0]}, {1'b0, v1[17:0]});
			v2 = {mam_pkg::SEL_MR2, 18'($urandom)};
			mode_write(v2);
			cmp(mr2[17:0], v2[17:0]);
			cmp({ondie_termination, term}, {1'b1, exp_term(v1, 1'b1)});
			// reserved select must leave all three registers alone
			mode_write({2'h3, 18'($urandom)});
			cmp(mr0, v0);
			cmp(mr1, v1);
			cmp(mr2, v2);
			refresh(1'b1);
			refresh(1'b0);
			// bit 9 low leaves mux mode; the next refresh takes a single edge
			v0 = mode_zero(1'b0);
			mode_write(v0);
			check_mode_zero(v0);
			refresh(1'($urandom));
			model.pin_reset();
			model.nop(3);
			check_reset();
			$display("test %0d done", r);
		end
		report_and_stop();
	end
endmodule
